// *** hdl/csh_core_seq.sv ***
// core sequencing: repeat control, pipeline occupancy, peripheral status lag, read-only shadow
// assumes all inputs come from core logic on MCLK_I; instruction decode happens upstream
`timescale 1ns/1ns
`include "csh_defs.svh"
module csh_core_seq #(
    parameter int STAGES = `CSH_PIPE_STAGES,
    parameter int STATUS_DELAY = `CSH_STATUS_DELAY_CYC,
    parameter int RO_SHADOW = `CSH_RO_SHADOW_CYC,
    parameter int DATA_W = `CSH_DATA_W,
    parameter int FLAG_W = `CSH_FLAG_W,
    parameter int ADDR_W = `CSH_ADDR_W,
    parameter int REP_W = `CSH_REP_W
) (
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic INSTR_VALID_I,
    input wire logic INSTR_REP_I,
    input wire logic [REP_W-1:0] REP_COUNT_I,
    input wire logic INSTR_FLOW_I,
    input wire logic INSTR_EXT_I,
    input wire logic INSTR_ARITH_PAIR_I,
    input wire logic INSTR_MOVE_CROSS_I,
    input wire logic INTERLOCK_I,
    input wire logic PERIPH_WR_I,
    input wire logic [FLAG_W-1:0] PERIPH_FLAG_I,
    input wire logic RO_WR_I,
    input wire logic RO_RD_I,
    input wire logic [ADDR_W-1:0] RO_ADDR_I,
    input wire logic [DATA_W-1:0] RO_WDATA_I,
    input wire logic [DATA_W-1:0] RO_TRUE_I,
    output logic ISSUE_O,
    output logic FETCH_HOLD_O,
    output logic REP_ILLEGAL_O,
    output logic MOVE_CORRUPT_O,
    output logic RETIRE_O,
    output logic PIPE_BUSY_O,
    output logic [FLAG_W-1:0] PERIPH_STATUS_O,
    output logic [DATA_W-1:0] RD_DATA_O
);
    if (STAGES < 2 || REP_W < 2 || STATUS_DELAY < 2 || RO_SHADOW < 1) begin : g_chk
        $error("csh_core_seq: parameter out of range");
    end

    csh_pkg::csh_rep_state_e state_q;
    csh_pkg::csh_rep_state_e state_d;
    logic [REP_W-1:0] remain_q;
    logic [REP_W-1:0] remain_d;
    logic corrupt_cond_q;
    logic [STAGES-1:0] pipe_q;
    logic issue_q;
    logic hold_q;
    logic illegal_q;
    logic corrupt_q;
    logic retire_q;
    logic busy_q;
    logic [FLAG_W-1:0] status_q;
    logic [DATA_W-1:0] rd_q;

    // repeat sequencing
    wire take_instr = INSTR_VALID_I & ~INTERLOCK_I;
    wire armed_take = (state_q == csh_pkg::CSH_REP_ARMED) & take_instr;
    wire rep_bad = INSTR_REP_I | INSTR_FLOW_I;
    wire rep_start = armed_take & ~rep_bad;
    wire running = (state_q == csh_pkg::CSH_REP_RUN);
    wire run_step = running & ~INTERLOCK_I;
    wire run_last = run_step & (remain_q == '0);
    // a count of zero or one runs the follower once, with no fetch hold
    wire rep_multi = (REP_COUNT_I > REP_W'(1));
    // the taking edge is the first pass, so the run state owes count minus one more
    wire [REP_W-1:0] first_remain = rep_multi ? REP_COUNT_I - REP_W'(2) : '0;
    wire corrupt_cond = INSTR_EXT_I & INSTR_ARITH_PAIR_I & INSTR_MOVE_CROSS_I;
    wire issue_d = running ? run_step : take_instr;

    always_comb begin
        state_d = state_q;
        remain_d = remain_q;
        unique case (state_q)
            csh_pkg::CSH_REP_IDLE: begin
                if (take_instr && INSTR_REP_I) begin
                    state_d = csh_pkg::CSH_REP_ARMED;
                    remain_d = REP_COUNT_I;
                end
            end
            csh_pkg::CSH_REP_ARMED: begin
                if (armed_take) begin
                    // an illegal follower runs once, no repetition
                    state_d = (rep_bad || !rep_multi) ? csh_pkg::CSH_REP_IDLE : csh_pkg::CSH_REP_RUN;
                    remain_d = first_remain;
                end
            end
            csh_pkg::CSH_REP_RUN: begin
                if (run_last) begin
                    state_d = csh_pkg::CSH_REP_IDLE;
                end else if (run_step) begin
                    remain_d = remain_q - REP_W'(1);
                end
            end
            default: begin
                state_d = csh_pkg::CSH_REP_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_q <= csh_pkg::CSH_REP_IDLE;
            remain_q <= '0;
            corrupt_cond_q <= 1'b0;
            issue_q <= 1'b0;
            hold_q <= 1'b0;
            illegal_q <= 1'b0;
            corrupt_q <= 1'b0;
        end else begin
            state_q <= state_d;
            remain_q <= remain_d;
            if (rep_start) begin
                corrupt_cond_q <= corrupt_cond;
            end
            issue_q <= issue_d;
            hold_q <= (state_d == csh_pkg::CSH_REP_RUN);
            illegal_q <= armed_take & rep_bad;
            // the final parallel move is lost; flag it to the move unit
            corrupt_q <= run_last & corrupt_cond_q;
        end
    end

    // busy follows the next stage contents so the output stays a plain flop
    wire busy_d = INTERLOCK_I ? (|pipe_q) : (|{pipe_q[STAGES-2:0], issue_d});

    // pipeline occupancy; interlock freezes all stages so no result is skipped
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            pipe_q <= '0;
            retire_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            if (!INTERLOCK_I) begin
                pipe_q <= {pipe_q[STAGES-2:0], issue_d};
            end
            retire_q <= pipe_q[STAGES-1] & ~INTERLOCK_I;
            busy_q <= busy_d;
        end
    end

    // peripheral status lag, old flags captured at the data write
    csh_win_if #(.W(FLAG_W)) stat_win ();
    assign stat_win.strobe = PERIPH_WR_I;
    // the live flag may already move at the write edge, so keep what software sees
    assign stat_win.data = status_q;
    wire [FLAG_W-1:0] stat_old = stat_win.active ? stat_win.held : PERIPH_FLAG_I;
    wire [FLAG_W-1:0] status_d = PERIPH_WR_I ? status_q : stat_old;

    // the write edge holds the first cycle, the window covers the rest
    csh_hold_window #(.W(FLAG_W), .LEN(STATUS_DELAY - 1)) u_stat_win (
        .clk_i(MCLK_I),
        .rst_i(RST_I),
        .win(stat_win)
    );

    // read-only shadow: written word is never stored in the true register
    csh_win_if #(.W(ADDR_W + DATA_W)) ro_win ();
    assign ro_win.strobe = RO_WR_I;
    assign ro_win.data = {RO_ADDR_I, RO_WDATA_I};
    wire ro_hit = ro_win.active & (ro_win.held[ADDR_W+DATA_W-1:DATA_W] == RO_ADDR_I);
    wire [DATA_W-1:0] rd_d = ro_hit ? ro_win.held[DATA_W-1:0] : RO_TRUE_I;

    csh_hold_window #(.W(ADDR_W + DATA_W), .LEN(RO_SHADOW)) u_ro_win (
        .clk_i(MCLK_I),
        .rst_i(RST_I),
        .win(ro_win)
    );

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            status_q <= '0;
            rd_q <= '0;
        end else begin
            status_q <= status_d;
            if (RO_RD_I) begin
                rd_q <= rd_d;
            end
        end
    end

    assign ISSUE_O = issue_q;
    assign FETCH_HOLD_O = hold_q;
    assign REP_ILLEGAL_O = illegal_q;
    assign MOVE_CORRUPT_O = corrupt_q;
    assign RETIRE_O = retire_q;
    assign PIPE_BUSY_O = busy_q;
    assign PERIPH_STATUS_O = status_q;
    assign RD_DATA_O = rd_q;

    a_rep_no_nest: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (state_q == csh_pkg::CSH_REP_ARMED && INSTR_VALID_I && !INTERLOCK_I && INSTR_REP_I)
        |=> REP_ILLEGAL_O && !FETCH_HOLD_O)
        else $error("nested repeat not refused");

    a_rep_hold_run: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (state_q == csh_pkg::CSH_REP_ARMED && INSTR_VALID_I && !INTERLOCK_I && !INSTR_REP_I
         && !INSTR_FLOW_I && REP_COUNT_I > REP_W'(2)) |=> FETCH_HOLD_O[*2])
        else $error("fetch not held during repeat");

    a_corrupt_last: assert property (@(posedge MCLK_I) disable iff (RST_I)
        MOVE_CORRUPT_O |-> $past(state_q == csh_pkg::CSH_REP_RUN) && !FETCH_HOLD_O)
        else $error("corrupt flag outside final iteration");

    a_pipe_depth: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (issue_d && !INTERLOCK_I) ##1 (!INTERLOCK_I)[*7] |=> RETIRE_O)
        else $error("instruction did not retire after seven stages");

    a_status_old: assert property (@(posedge MCLK_I) disable iff (RST_I)
        PERIPH_WR_I ##1 !PERIPH_WR_I |=> PERIPH_STATUS_O == $past(PERIPH_STATUS_O, 1))
        else $error("status changed inside write lag");

    a_status_hold: assert property (@(posedge MCLK_I) disable iff (RST_I)
        PERIPH_WR_I |=> PERIPH_STATUS_O == $past(PERIPH_STATUS_O))
        else $error("status moved at peripheral write");

    a_ro_shadow: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (RO_WR_I ##1 (RO_RD_I && !RO_WR_I && RO_ADDR_I == $past(RO_ADDR_I)))
        |=> RD_DATA_O == $past(RO_WDATA_I, 2))
        else $error("read after read-only write missed shadow");
endmodule

// *** pkg/csh_defs.svh ***
// constants for the core sequence and hazard block
// assumes inclusion by bare name from design files
`ifndef CSH_DEFS_SVH
`define CSH_DEFS_SVH

`define CSH_PIPE_STAGES 7
`define CSH_STATUS_DELAY_CYC 2
`define CSH_RO_SHADOW_CYC 2
`define CSH_DATA_W 24
`define CSH_FLAG_W 8
`define CSH_ADDR_W 6
`define CSH_REP_W 12

`endif

// *** pkg/csh_pkg.sv ***
// types for the core sequence and hazard block
// assumes nothing beyond a sv compiler
package csh_pkg;

    // gray codes along idle -> armed -> repeating; repeating -> idle flips both bits
    typedef enum logic [1:0] {
        CSH_REP_IDLE = 2'h0,
        CSH_REP_ARMED = 2'h1,
        CSH_REP_RUN = 2'h3
    } csh_rep_state_e;

endpackage

// *** pkg/csh_win_if.sv ***
// carrier between the top and a hold-window module
// assumes one clock shared by both ends
`timescale 1ns/1ns
interface csh_win_if #(
    parameter int W = 8
);
    logic strobe;
    logic [W-1:0] data;
    logic active;
    logic [W-1:0] held;

    modport owner (input strobe, input data, output active, output held);
    modport user (output strobe, output data, input active, input held);
endinterface

// *** hdl/csh_hold_window.sv ***
// captures a word on a strobe and flags it live for a fixed window
// assumes strobe and data come from logic on the same clock
`timescale 1ns/1ns
module csh_hold_window #(
    parameter int W = 8,
    parameter int LEN = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    csh_win_if.owner win
);
    localparam int CW = $clog2(LEN + 1);
    localparam logic [CW-1:0] LEN_C = CW'(LEN);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic [W-1:0] held_q;

    if (LEN < 1 || W < 1) begin : g_chk
        $error("csh_hold_window: LEN and W must be at least 1");
    end

    // a new strobe restarts the window, latest word wins
    assign cnt_d = win.strobe ? LEN_C : ((cnt_q != '0) ? cnt_q - CW'(1) : cnt_q);
    assign win.active = (cnt_q != '0);
    assign win.held = held_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            held_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            if (win.strobe) begin
                held_q <= win.data;
            end
        end
    end
endmodule

// *** testbench/csh_prog_model.sv ***
// instruction stream model feeding the core one decoded instruction a cycle
// assumes go_i is a one-cycle request on clk_i, ignored while a burst runs
`timescale 1ns/1ns
module csh_prog_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic rep_i,
    input wire logic bad_i,
    input wire logic nest_i,
    input wire logic [2:0] hazard_i,
    output logic valid_o,
    output logic rep_o,
    output logic flow_o,
    output logic [2:0] hazard_o
);
    // phase: 1 repeat, 2 follower, 3 plain instruction
    logic [1:0] ph_q;
    logic [1:0] ph_d;
    assign ph_d = (ph_q == 2'h1) ? 2'h2 : (go_i && ph_q == 2'h0) ? (rep_i ? 2'h1 : 2'h3) : 2'h0;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ph_q <= 2'h0;
        end else begin
            // never a fast interrupt routine, error vector, dual move or interrupt return
            ph_q <= ph_d;
        end
    end
    // no stack, loop or extension register is ever touched, so no spacing is owed
    assign valid_o = (ph_q != 2'h0);
    // a nested repeat only when a scenario asks for the fault
    assign rep_o = (ph_q == 2'h1) || ((ph_q == 2'h2) && nest_i);
    // flow change after a repeat only when a scenario asks for the fault
    assign flow_o = (ph_q == 2'h2) && bad_i;
    // hazardous repeated move only on request, else result moved afterwards
    assign hazard_o = (ph_q == 2'h2) ? hazard_i : 3'h0;
endmodule

// *** testbench/tb.sv ***
// self-checking bench for the core sequencing block
// assumes default parameters of the core sequencing block
`timescale 1ns/1ns
module tb;
    logic mclk = 1'b0, rst = 1'b1, go = 1'b0, rep = 1'b0, bad = 1'b0, nest = 1'b0, lock = 1'b0;
    logic [2:0] haz = 3'h0;
    logic pwr = 1'b0, rwr = 1'b0, rrd = 1'b0;
    logic [11:0] cnt = 12'h000;
    logic [7:0] flag = 8'h00, status;
    logic [5:0] addr = 6'h00;
    logic [23:0] wdata = 24'h000000, tru = 24'h000000, rdata;
    logic v, r, f, iss, hold, ill, cor, ret, busy;
    logic [2:0] h;
    int err_total = 0, total_checks = 0, cyc = 0, n_iss = 0, n_hold = 0, n_ill = 0, n_cor = 0;
    int iss_at = 0, ret_at = 0, cor_at = 0;
    always #2 mclk = ~mclk;
    csh_prog_model u_csh_prog_model (.clk_i(mclk), .rst_i(rst), .go_i(go), .rep_i(rep), .bad_i(bad),
        .nest_i(nest), .hazard_i(haz), .valid_o(v), .rep_o(r), .flow_o(f), .hazard_o(h));
    csh_core_seq u_csh_core_seq (.MCLK_I(mclk), .RST_I(rst), .INSTR_VALID_I(v), .INSTR_REP_I(r),
        .REP_COUNT_I(cnt), .INSTR_FLOW_I(f), .INSTR_EXT_I(h[2]), .INSTR_ARITH_PAIR_I(h[1]),
        .INSTR_MOVE_CROSS_I(h[0]), .INTERLOCK_I(lock), .PERIPH_WR_I(pwr), .PERIPH_FLAG_I(flag),
        .RO_WR_I(rwr), .RO_RD_I(rrd), .RO_ADDR_I(addr), .RO_WDATA_I(wdata), .RO_TRUE_I(tru),
        .ISSUE_O(iss), .FETCH_HOLD_O(hold), .REP_ILLEGAL_O(ill), .MOVE_CORRUPT_O(cor),
        .RETIRE_O(ret), .PIPE_BUSY_O(busy), .PERIPH_STATUS_O(status), .RD_DATA_O(rdata));
    // pulse tallies sampled mid-cycle, away from the launching edge
    always @(negedge mclk) begin
        cyc++;
        if (iss === 1'b1) begin
            n_iss++;
            iss_at = cyc;
        end
        if (hold === 1'b1) begin
            n_hold++;
        end
        if (ill === 1'b1) begin
            n_ill++;
        end
        if (cor === 1'b1) begin
            n_cor++;
            cor_at = cyc;
        end
        if (ret === 1'b1) begin
            ret_at = cyc;
        end
    end
    task automatic step(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic check(logic ok, string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic launch(logic rp, logic bd, logic [2:0] hz, logic [11:0] c);
        rep = rp;
        bad = bd;
        haz = hz;
        cnt = c;
        go = 1'b1;
        step(1);
        go = 1'b0;
        step(16);
    endtask
    task automatic sc_rep(logic [11:0] c, int e_iss, int e_hold);
        int i0, h0, c0;
        i0 = n_iss;
        h0 = n_hold;
        c0 = n_cor;
        launch(1'b1, 1'b0, 3'h0, c);
        check(n_iss - i0 == e_iss, "repeat issue count");
        check(n_hold - h0 == e_hold && n_cor == c0, "repeat hold span");
    endtask
    task automatic sc_illegal();
        int i0;
        i0 = n_ill;
        launch(1'b1, 1'b1, 3'h0, 12'h002);
        check(n_ill - i0 == 1, "flow change after repeat not flagged");
        nest = 1'b1;
        launch(1'b1, 1'b0, 3'h0, 12'h002);
        nest = 1'b0;
        check(n_ill - i0 == 2, "repeat after repeat not flagged");
    endtask
    task automatic sc_corrupt();
        int c0;
        c0 = n_cor;
        launch(1'b1, 1'b0, 3'h3, 12'h003);
        check(n_cor == c0, "corrupt flag with internal fetch");
        launch(1'b1, 1'b0, 3'h7, 12'h003);
        check(n_cor - c0 == 1 && cor_at == iss_at, "corrupt move at last pass");
    endtask
    task automatic sc_pipe();
        int i0;
        i0 = n_iss;
        launch(1'b0, 1'b0, 3'h0, 12'h000);
        check(n_iss - i0 == 1 && ret_at - iss_at == 7, "seven stage retire");
        check(busy === 1'b0, "busy after retire");
    endtask
    task automatic sc_lock();
        int i0;
        i0 = n_iss;
        lock = 1'b1;
        launch(1'b0, 1'b0, 3'h0, 12'h000);
        lock = 1'b0;
        check(n_iss == i0, "issue during interlock");
        go = 1'b1;
        step(1);
        go = 1'b0;
        step(3);
        lock = 1'b1;
        step(3);
        check(busy === 1'b1, "busy while frozen");
        lock = 1'b0;
        step(16);
        check(ret_at - iss_at == 10, "interlock freeze");
    endtask
    task automatic sc_status();
        flag = 8'h01;
        step(4);
        check(status === 8'h01, "live flags");
        pwr = 1'b1;
        flag = 8'h80;
        step(1);
        pwr = 1'b0;
        check(status === 8'h01, "old flag lost early");
        step(1);
        check(status === 8'h01, "old flag lost second cycle");
        step(1);
        check(status === 8'h80, "new flag late");
    endtask
    task automatic sc_shadow();
        addr = 6'h05;
        wdata = 24'h123456;
        tru = 24'habcdef;
        rwr = 1'b1;
        step(1);
        rwr = 1'b0;
        rrd = 1'b1;
        wdata = 24'h000000;
        step(1);
        check(rdata === 24'h123456, "shadow first");
        step(1);
        check(rdata === 24'h123456, "shadow second");
        step(1);
        rrd = 1'b0;
        check(rdata === 24'habcdef, "true value after window");
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        err_total++;
        conclude();
    end
    initial begin
        step(16);
        rst = 1'b0;
        step(2);
        sc_pipe();
        sc_rep(12'h003, 4, 2);
        sc_rep(12'h000, 2, 0);
        sc_illegal();
        sc_corrupt();
        sc_lock();
        sc_status();
        sc_shadow();
        conclude();
    end
endmodule
